// ===== src/sfmc_controller.sv
// ********************************
// staging fifo
// ********************************
module sfmc_stage_fifo #(
    parameter int W = 40,
    parameter int D = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;
    assign in_ready = cnt_r < (AW+1)'(D);
    assign out_valid = cnt_r != '0;
    assign out_data = mem_r[rp_r];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
            if (do_rd) rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) mem_r[wp_r] <= in_data;
    end
endmodule

// ********************************
// sample queue and mode control
// ********************************
module sfmc_controller
    import sfmc_pkg::*;
#(
    parameter int DEPTH = Q_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic [6:0] reg_next_addr,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic [P_W-1:0] sample_press,
    input wire logic [T_W-1:0] sample_temp,
    input wire logic interrupt_active_flag,
    output logic [7:0] event_cfg,
    output logic ready_irq_pad
);
    localparam int SW = P_W + T_W;
    localparam int AW = $clog2(DEPTH);

    // ********************************
    // registers
    // ********************************
    logic [7:0] evt_cfg_r;
    logic [7:0] route_r;
    logic [7:0] mode_r;
    logic [7:0] thr_r;
    logic [SW-1:0] mem_r [DEPTH];
    logic [SW-1:0] last_r;
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [7:0] count_r;
    logic ovr_r;
    logic trig_seen_r;
    logic ia_d_r;
    logic [7:0] rdata_r;
    logic [6:0] next_addr_r;
    logic irq_r;

    // ********************************
    // staging path
    // ********************************
    logic drain_valid;
    logic drain_ready;
    logic [SW-1:0] drain_data;

    sfmc_stage_fifo #(.W(SW), .D(STAGE_DEPTH)) u_stage (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data({sample_press, sample_temp}),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_data)
    );

    // ********************************
    // mode decode
    // ********************************
    wire [2:0] sel = mode_r[2:0];
    wire stop_at_threshold = mode_r[MODE_STOP_BIT];
    wire [6:0] threshold_level = thr_r[6:0];
    wire threshold_irq_enable = route_r[ROUTE_WTM_IE_BIT];
    wire sel_is_byp = (sel == SEL_BYP_A) || (sel == SEL_BYP_B);
    wire sel_is_trig = sel[2] && (sel[1] || sel[0]);
    wire ia_rise = interrupt_active_flag && !ia_d_r;
    wire mode_wr = reg_wr && (reg_addr == ADDR_MODE);
    wire mode_wr_byp = mode_wr && ((reg_wdata[2:0] == SEL_BYP_A)
        || (reg_wdata[2:0] == SEL_BYP_B));
    sfmc_beh_t beh;

    always_comb begin
        case (sel)
            SEL_FIFO: beh = BEH_FIFO;
            SEL_CONT: beh = BEH_CONT;
            SEL_B2F: beh = trig_seen_r ? BEH_FIFO : BEH_BYP;
            SEL_B2C: beh = trig_seen_r ? BEH_CONT : BEH_BYP;
            SEL_C2F: beh = trig_seen_r ? BEH_FIFO : BEH_CONT;
            default: beh = BEH_BYP;
        endcase
    end

    // ********************************
    // queue control
    // ********************************
    // depth may drop below the count when the threshold shrinks;
    // compares use >= so nothing wraps
    wire [7:0] eff_depth = stop_at_threshold ? {1'b0, threshold_level}
        : 8'(DEPTH);
    wire full = count_r >= eff_depth;
    wire is_byp = beh == BEH_BYP;
    wire pop = reg_rd && (reg_addr == ADDR_Q_T_HI)
        && (count_r != 8'h00) && !is_byp;
    // a pop stalls the drain for one cycle: simpler pointers, staging absorbs it
    assign drain_ready = !pop;
    wire push = drain_valid && drain_ready;
    wire push_new = push && !is_byp && !full;
    wire push_ovw = push && (beh == BEH_CONT) && full
        && (eff_depth != 8'h00);
    wire wtm_flag = (threshold_level != 7'h00)
        && (count_r >= {1'b0, threshold_level});
    wire [SW-1:0] head = mem_r[rp_r];

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            count_r <= 8'h00;
            ovr_r <= 1'b0;
        end else if (is_byp || mode_wr_byp) begin
            wp_r <= '0;
            rp_r <= '0;
            count_r <= 8'h00;
            ovr_r <= 1'b0;
        end else begin
            if (push_new || push_ovw) wp_r <= inc(wp_r);
            if (pop || push_ovw) rp_r <= inc(rp_r);
            if (push_new) count_r <= count_r + 8'h01;
            else if (pop) count_r <= count_r - 8'h01;
            // set wins over the clear by a pop
            if (push_ovw) ovr_r <= 1'b1;
            else if (pop) ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (push && is_byp) mem_r[0] <= drain_data;
        else if (push_new || push_ovw) mem_r[wp_r] <= drain_data;
    end

    // ********************************
    // trigger latch
    // ********************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_seen_r <= 1'b0;
            ia_d_r <= 1'b0;
        end else begin
            ia_d_r <= interrupt_active_flag;
            // a rise in the cycle of a mode write still counts: set wins
            if (ia_rise && sel_is_trig) trig_seen_r <= 1'b1;
            else if (mode_wr || !sel_is_trig) trig_seen_r <= 1'b0;
        end
    end

    // ********************************
    // register port
    // ********************************
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_cfg_r <= RST_BYTE;
            route_r <= RST_BYTE;
            mode_r <= RST_BYTE;
            thr_r <= RST_BYTE;
            last_r <= '0;
        end else begin
            if (reg_wr && reg_addr == ADDR_EVT_CFG) evt_cfg_r <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_ROUTE) route_r <= reg_wdata;
            if (mode_wr) mode_r <= reg_wdata;
            if (reg_wr && reg_addr == ADDR_THR) thr_r <= {1'b0, reg_wdata[6:0]};
            if (push) last_r <= drain_data;
        end
    end

    // in bypass the queued view shows slot zero, the single live sample
    wire [SW-1:0] q_view = is_byp ? mem_r[0] : head;
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            ADDR_EVT_CFG: rd_mux = evt_cfg_r;
            ADDR_ROUTE: rd_mux = route_r;
            ADDR_MODE: rd_mux = mode_r;
            ADDR_THR: rd_mux = thr_r;
            ADDR_SRC: rd_mux = 8'(interrupt_active_flag) << SRC_IA_BIT;
            ADDR_LEVEL: rd_mux = count_r;
            ADDR_FLAGS: rd_mux = (8'(wtm_flag) << FLAG_WTM_BIT)
                | (8'(ovr_r) << FLAG_OVR_BIT);
            ADDR_P_LO: rd_mux = last_r[23:16];
            ADDR_P_MID: rd_mux = last_r[31:24];
            ADDR_P_HI: rd_mux = last_r[39:32];
            ADDR_T_LO: rd_mux = last_r[7:0];
            ADDR_T_HI: rd_mux = last_r[15:8];
            ADDR_Q_P_LO: rd_mux = q_view[23:16];
            ADDR_Q_P_MID: rd_mux = q_view[31:24];
            ADDR_Q_P_HI: rd_mux = q_view[39:32];
            ADDR_Q_T_LO: rd_mux = q_view[7:0];
            ADDR_Q_T_HI: rd_mux = q_view[15:8];
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
            next_addr_r <= 7'h00;
            irq_r <= 1'b0;
        end else begin
            if (reg_rd) rdata_r <= rd_mux;
            if (reg_rd || reg_wr)
                next_addr_r <= (reg_addr == ADDR_Q_T_HI) ? ADDR_Q_P_LO
                    : reg_addr + 7'h01;
            irq_r <= wtm_flag && threshold_irq_enable;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_next_addr = next_addr_r;
    assign event_cfg = evt_cfg_r;
    assign ready_irq_pad = irq_r;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_bypass_empty:
    assert property (is_byp |=> count_r == 8'h00)
        else $error("bypass left queue non-empty");
    chk_bypass_clear:
    assert property (mode_wr_byp |=> count_r == 8'h00 && wp_r == '0)
        else $error("bypass entry did not clear queue");
    chk_fill_push:
    assert property (push_new && beh == BEH_FIFO && !mode_wr
        |=> count_r == $past(count_r) + 8'h01)
        else $error("fill mode missed a sample");
    chk_full_hold:
    assert property (beh == BEH_FIFO && full && push && !mode_wr
        |=> count_r == $past(count_r) && wp_r == $past(wp_r))
        else $error("full queue accepted a sample");
    chk_overrun_set:
    assert property (push_ovw && !mode_wr |=> ovr_r && count_r == $past(count_r))
        else $error("overwrite did not flag overrun");
    chk_thr_zero:
    assert property (threshold_level == 7'h00 |-> !wtm_flag)
        else $error("threshold flag with zero threshold");
    chk_irq_pad:
    assert property (wtm_flag && threshold_irq_enable |=> ready_irq_pad)
        else $error("threshold interrupt missing");
    chk_addr_wrap:
    assert property (reg_rd && reg_addr == ADDR_Q_T_HI
        |=> reg_next_addr == ADDR_Q_P_LO)
        else $error("read address did not wrap");
    chk_pop_count:
    assert property (pop && !mode_wr |=> count_r == $past(count_r) - 8'h01)
        else $error("group read did not pop");
    chk_level_read:
    assert property (reg_rd && reg_addr == ADDR_LEVEL |=> reg_rdata == $past(count_r))
        else $error("level read mismatch");
    chk_trig_fill:
    assert property (sel == SEL_B2F && ia_rise && !mode_wr
        |=> beh == BEH_FIFO ##1 (beh == BEH_FIFO || $past(mode_wr)))
        else $error("trigger did not switch to fill");
    chk_count_max:
    assert property (count_r <= 8'(DEPTH))
        else $error("count above depth");
    chk_bypass_slot:
    assert property (push && is_byp |=> mem_r[0] == $past(drain_data))
        else $error("bypass did not refresh slot zero");
    chk_trig_cont:
    assert property (sel == SEL_B2C && ia_rise && !mode_wr |=> beh == BEH_CONT)
        else $error("trigger did not switch to continuous");
    chk_trig_c2f:
    assert property (sel == SEL_C2F && ia_rise && !mode_wr |=> beh == BEH_FIFO)
        else $error("trigger did not end continuous storing");
    chk_depth_limit:
    assert property (stop_at_threshold && beh == BEH_FIFO && push && !mode_wr
        && count_r >= {1'b0, threshold_level} |=> count_r == $past(count_r))
        else $error("fill passed the threshold depth");
    chk_wtm_read:
    assert property (reg_rd && reg_addr == ADDR_FLAGS && threshold_level != 7'h00
        && count_r >= {1'b0, threshold_level} |=> reg_rdata[FLAG_WTM_BIT])
        else $error("threshold flag not reported");
    chk_bypass_ovr:
    assert property (mode_wr_byp |=> !ovr_r)
        else $error("bypass entry left overrun set");
    chk_irq_gate:
    assert property (!threshold_irq_enable |=> !ready_irq_pad)
        else $error("threshold interrupt while disabled");
    chk_empty_pop:
    assert property (count_r == 8'h00 && reg_rd && reg_addr == ADDR_Q_T_HI
        |=> count_r <= 8'h01)
        else $error("read of empty queue wrapped the count");
endmodule

// ===== src/sfmc_pkg.sv
// How it works
// - modes 000/100 keep queue empty
// - entering bypass clears queue contents
// - bypass overwrites first slot per channel
// - mode 001 stores samples until full
// - depth 128, or threshold when stop set
// - continuous: oldest unread sample read first
// - level count shows unread samples
// - threshold interrupt on ready pad, enabled
// - mode 101: bypass, then fill after trigger
// - mode 110: bypass, then continuous after trigger
// - mode 111: continuous, then fill after trigger
// - queue read address wraps 7c to 78
// - slot holds 24-bit pressure, 16-bit temperature
// - threshold flag when count >= nonzero threshold
// - overrun flag on unread slot overwrite
// - count 00h empty, 80h full
package sfmc_pkg;
    // ********************************
    // register offsets
    // ********************************
    localparam logic [6:0] ADDR_EVT_CFG = 7'h0b;
    localparam logic [6:0] ADDR_ROUTE = 7'h12;
    localparam logic [6:0] ADDR_MODE = 7'h13;
    localparam logic [6:0] ADDR_THR = 7'h14;
    localparam logic [6:0] ADDR_SRC = 7'h24;
    localparam logic [6:0] ADDR_LEVEL = 7'h25;
    localparam logic [6:0] ADDR_FLAGS = 7'h26;
    localparam logic [6:0] ADDR_P_LO = 7'h28;
    localparam logic [6:0] ADDR_P_MID = 7'h29;
    localparam logic [6:0] ADDR_P_HI = 7'h2a;
    localparam logic [6:0] ADDR_T_LO = 7'h2b;
    localparam logic [6:0] ADDR_T_HI = 7'h2c;
    localparam logic [6:0] ADDR_Q_P_LO = 7'h78;
    localparam logic [6:0] ADDR_Q_P_MID = 7'h79;
    localparam logic [6:0] ADDR_Q_P_HI = 7'h7a;
    localparam logic [6:0] ADDR_Q_T_LO = 7'h7b;
    localparam logic [6:0] ADDR_Q_T_HI = 7'h7c;
    // ********************************
    // fields and reset values
    // ********************************
    localparam int MODE_STOP_BIT = 3;
    localparam int ROUTE_WTM_IE_BIT = 2;
    localparam int SRC_IA_BIT = 2;
    localparam int FLAG_WTM_BIT = 7;
    localparam int FLAG_OVR_BIT = 6;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int Q_DEPTH = 128;
    localparam int STAGE_DEPTH = 16;
    localparam int P_W = 24;
    localparam int T_W = 16;
    // ********************************
    // mode selections and behaviours
    // ********************************
    localparam logic [2:0] SEL_BYP_A = 3'h0;
    localparam logic [2:0] SEL_FIFO = 3'h1;
    localparam logic [2:0] SEL_CONT = 3'h3;
    localparam logic [2:0] SEL_BYP_B = 3'h4;
    localparam logic [2:0] SEL_B2F = 3'h5;
    localparam logic [2:0] SEL_B2C = 3'h6;
    localparam logic [2:0] SEL_C2F = 3'h7;
    typedef enum logic [1:0] {
        BEH_BYP = 2'b00,
        BEH_FIFO = 2'b01,
        BEH_CONT = 2'b10
    } sfmc_beh_t;
endpackage

// ===== tb/sfmc_controller_bench.sv
module sfmc_controller_bench
    import sfmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, reg_wr, reg_rd, sample_valid, sample_ready;
    logic interrupt_active_flag, ready_irq_pad;
    logic [6:0] reg_addr, reg_next_addr;
    logic [7:0] reg_wdata, reg_rdata, event_cfg, d;
    logic [P_W-1:0] sample_press;
    logic [T_W-1:0] sample_temp;
    logic [31:0] rs = 32'h9070;
    logic [39:0] smp [0:129];
    logic [39:0] v;
    int err_count = 0;
    int checks = 0;

    sfmc_controller dut_u (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_next_addr(reg_next_addr), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .sample_press(sample_press),
        .sample_temp(sample_temp), .interrupt_active_flag(interrupt_active_flag),
        .event_cfg(event_cfg), .ready_irq_pad(ready_irq_pad)
    );
    sfmc_host_model host_u (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (100000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    function automatic logic [39:0] rnd();
        rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
        return {rs, rs[23:16]};
    endfunction
    // a slot as read back from 78h upward, lowest byte first
    function automatic logic [39:0] lvl(input logic [39:0] s);
        return {s[15:0], s[39:16]};
    endfunction

    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] m, input logic [7:0] e);
        host_u.rd(a, d);
        chk({32'h0, d & m}, {32'h0, e});
    endtask
    // held until taken, then time for the staging stage to drain
    task automatic push(input logic [39:0] s);
        int n = 0;
        @(negedge clk);
        sample_valid = 1'b1;
        {sample_press, sample_temp} = s;
        while (sample_ready !== 1'b1 && n < 64) begin
            @(negedge clk);
            n++;
        end
        if (n == 64) begin
            err_count++;
            wrap_up();
        end
        @(negedge clk);
        sample_valid = 1'b0;
        {sample_press, sample_temp} = ~s;
        repeat (3) @(negedge clk);
    endtask
    task automatic rd_level(input logic [39:0] s);
        for (int i = 0; i < 5; i++) begin
            host_u.rd(ADDR_Q_P_LO + 7'(i), v[8*i+:8]);
        end
        chk(v, lvl(s));
        chk({33'h0, reg_next_addr}, 40'h78);
    endtask

    initial begin
        sys_rst = 1'b1;
        sample_valid = 1'b0;
        {sample_press, sample_temp} = 40'h0;
        interrupt_active_flag = 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        rdc(ADDR_LEVEL, 8'hff, 8'h00);
        rdc(ADDR_MODE, 8'hff, 8'h00);
        rdc(7'h50, 8'hff, 8'h00);
        host_u.wr(ADDR_EVT_CFG, 8'ha5);
        rdc(ADDR_EVT_CFG, 8'hff, 8'ha5);
        chk({32'h0, event_cfg}, 40'ha5);
        host_u.wr(ADDR_THR, 8'hff);
        rdc(ADDR_THR, 8'hff, 8'h7f);
        host_u.wr(ADDR_LEVEL, 8'h3c);
        // ********************************
        // bypass, both selections
        // ********************************
        for (int m = 0; m < 2; m++) begin
            host_u.wr(ADDR_MODE, {5'h0, m[0], 2'h0});
            push(40'hffffffffff);
            v = rnd();
            push(v);
            smp[0] = lvl(v);
            rdc(ADDR_LEVEL, 8'hff, 8'h00);
            for (int i = 0; i < 5; i++) begin
                rdc(ADDR_P_LO + 7'(i), 8'hff, smp[0][8*i+:8]);
            end
            rd_level(v);
        end
        // ********************************
        // fill mode limited to threshold 4
        // ********************************
        host_u.wr(ADDR_THR, 8'h04);
        host_u.wr(ADDR_MODE, 8'h09);
        for (int i = 0; i < 6; i++) begin
            smp[i] = rnd();
            push(smp[i]);
        end
        rdc(ADDR_LEVEL, 8'hff, 8'h04);
        rdc(ADDR_FLAGS, 8'hc0, 8'h80);
        chk({39'h0, ready_irq_pad}, 40'h0);
        host_u.wr(ADDR_ROUTE, 8'h04);
        rdc(ADDR_ROUTE, 8'hff, 8'h04);
        chk({39'h0, ready_irq_pad}, 40'h1);
        rd_level(smp[0]);
        rd_level(smp[1]);
        rdc(ADDR_LEVEL, 8'hff, 8'h02);
        chk({39'h0, ready_irq_pad}, 40'h0);
        host_u.wr(ADDR_MODE, 8'h00);
        rdc(ADDR_LEVEL, 8'hff, 8'h00);
        host_u.wr(ADDR_MODE, 8'h09);
        smp[0] = rnd();
        push(smp[0]);
        rd_level(smp[0]);
        // ********************************
        // continuous, overrun, slow host
        // ********************************
        host_u.wr(ADDR_MODE, 8'h00);
        host_u.wr(ADDR_THR, 8'h00);
        host_u.wr(ADDR_MODE, 8'h03);
        for (int i = 0; i < 130; i++) begin
            smp[i] = rnd();
            push(smp[i]);
        end
        rdc(ADDR_LEVEL, 8'hff, 8'h80);
        rdc(ADDR_FLAGS, 8'hc0, 8'h40);
        host_u.gap = 1;
        for (int i = 2; i < 130; i++) begin
            rd_level(smp[i]);
        end
        rdc(ADDR_LEVEL, 8'hff, 8'h00);
        smp[0] = rnd();
        push(smp[0]);
        smp[1] = rnd();
        push(smp[1]);
        rdc(ADDR_LEVEL, 8'hff, 8'h02);
        rd_level(smp[0]);
        host_u.gap = 0;
        // ********************************
        // trigger switched selections
        // ********************************
        for (int m = 5; m < 8; m++) begin
            host_u.wr(ADDR_MODE, 8'h00);
            host_u.wr(ADDR_THR, 8'h03);
            host_u.wr(ADDR_MODE, 8'h08 | 8'(m));
            push(rnd());
            push(rnd());
            rdc(ADDR_LEVEL, 8'hff, m == 7 ? 8'h02 : 8'h00);
            @(negedge clk);
            interrupt_active_flag = 1'b1;
            rdc(ADDR_SRC, 8'h04, 8'h04);
            interrupt_active_flag = 1'b0;
            for (int i = 0; i < 4; i++) begin
                push(rnd());
            end
            rdc(ADDR_LEVEL, 8'hff, 8'h03);
            rdc(ADDR_FLAGS, 8'h40, m == 6 ? 8'h40 : 8'h00);
        end
        wrap_up();
    end
endmodule

// ===== tb/sfmc_host_model.sv
module sfmc_host_model (
    input wire logic clk,
    output logic [6:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // ********************************
    // byte accesses, one strobe each
    // ********************************
    // released lines carry the inverse so stale values never look valid
    task automatic wr(input logic [6:0] a, input logic [7:0] x);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = x;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~x;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] x);
        repeat (gap) @(negedge clk);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        x = reg_rdata;
    endtask
endmodule
